// >>> pkg/acl_staging_pkg.sv
/*
  Constants shared by the ACL entry staging bank and its entry memory.
  Assumes a 32-bit AXI4-Lite bus; each 8-bit register sits in the low byte
  of one aligned word at byte address four times its index.
*/
`default_nettype none

package acl_staging_pkg;

  localparam int AXI_ADDR_W = 14;
  localparam int AXI_DATA_W = 32;
  localparam int IDX_W      = 12;
  localparam int BYTE_W     = 8;
  localparam int ENTRY_BYTES = 16;
  localparam int ENTRY_W    = 128;
  localparam int ACL_DEPTH  = 16;
  localparam int ACL_IDX_W  = 4;

  // register indices
  localparam logic [11:0] IDX_MAC_ADDR_23_16  = 12'h605;
  localparam logic [11:0] IDX_MAC_ADDR_15_8   = 12'h606;
  localparam logic [11:0] IDX_MAC_ADDR_7_0    = 12'h607;
  localparam logic [11:0] IDX_ETHERTYPE_HIGH  = 12'h608;
  localparam logic [11:0] IDX_ETHERTYPE_LOW   = 12'h609;
  localparam logic [11:0] IDX_PRIO_REMARK     = 12'h60a;
  localparam logic [11:0] IDX_REMARK_MAP_MODE = 12'h60b;
  localparam logic [11:0] IDX_RESERVED_BYTE   = 12'h60c;
  localparam logic [11:0] IDX_FORWARD_MAP     = 12'h60d;
  localparam logic [11:0] IDX_RULESET_HIGH    = 12'h60e;
  localparam logic [11:0] IDX_RULESET_LOW     = 12'h60f;
  localparam logic [11:0] IDX_BYTE_SEL_HIGH   = 12'h610;
  localparam logic [11:0] IDX_BYTE_SEL_LOW    = 12'h611;
  localparam logic [11:0] IDX_ACCESS_CTRL     = 12'h612;

  // staging byte numbers
  localparam logic [3:0] BYTE_PRIO      = 4'ha;
  localparam logic [3:0] BYTE_MAP_MODE  = 4'hb;
  localparam logic [3:0] BYTE_FWD_MAP   = 4'hd;
  localparam logic [3:0] BYTE_RULES_HI  = 4'he;
  localparam logic [3:0] BYTE_RULES_LO  = 4'hf;

  // field positions
  localparam int PM_HI      = 7;
  localparam int PM_LO      = 6;
  localparam int PRIO_HI    = 5;
  localparam int PRIO_LO    = 3;
  localparam int RPE_BIT    = 2;
  localparam int RMK_UP_HI  = 1;
  localparam int RMK_UP_LO  = 0;
  localparam int RMK_LSB    = 7;
  localparam int MM_HI      = 6;
  localparam int MM_LO      = 5;
  localparam int FWD_HI     = 6;
  localparam int FWD_LO     = 0;
  localparam int CTRL_WR_DONE = 6;
  localparam int CTRL_RD_DONE = 5;
  localparam int CTRL_DIR     = 4;

  // reset values
  localparam logic [7:0] STAGE_RESET = 8'h00;
  localparam logic [7:0] SEL_RESET   = 8'h00;
  localparam logic       DONE_RESET  = 1'b1;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    XFER_IDLE,
    XFER_WRITE,
    XFER_RD_ISSUE,
    XFER_RD_LOAD
  } xfer_state_t;

endpackage : acl_staging_pkg

`default_nettype wire

// >>> logic/acl_entry_mem.sv
/*
  ACL entry table: 16 entries of 16 bytes, byte-lane write enables,
  registered read data one cycle after the read strobe.
  Assumes a single clock; contents are not reset.
*/
`timescale 1ns/1ps
`default_nettype none

module acl_entry_mem (
  input  wire logic         clk_in,
  input  wire logic         wr_en_in,
  input  wire logic         rd_en_in,
  input  wire logic [3:0]   addr_in,
  input  wire logic [15:0]  lane_en_in,
  input  wire logic [127:0] wdata_in,
  output logic      [127:0] rdata_out
);

  logic [127:0] mem_r [acl_staging_pkg::ACL_DEPTH];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      for (int i = 0; i < acl_staging_pkg::ENTRY_BYTES; i++) begin
        if (lane_en_in[i]) begin
          mem_r[addr_in][8*i +: 8] <= wdata_in[8*i +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rd_en_in) begin
      rdata_out <= mem_r[addr_in];
    end
  end

endmodule : acl_entry_mem

`default_nettype wire

// >>> logic/acl_entry_staging_regs.sv
/*
  Per-port ACL entry staging registers behind an AXI4-Lite slave, with the
  indirect transfer engine that moves selected bytes to or from the table.
  Assumes one 125 MHz clock and an asynchronous active-low reset.
*/
// Summary of operation
// (R1) A transfer starts when the low byte-select register is written, so it goes last.
// (R2) High select bit k chooses staging byte 7-k.
// (R3) Low select bit k chooses staging byte 15-k.
// (R4) Only bytes whose select bit is one are read or written.
// (R5) Remark priority bits 2:1 sit in priority bits 1:0, bit 0 in map-mode bit 7.
// (R6) Forward map bit i enables forwarding to port i+1.
// (R7) Priority register holds mode 7:6, priority 5:3 and remark enable at bit 2.
// (R8) Multi-byte fields sit most significant byte first and staging resets to zero.
// (R9) Read-done at control bit 5 is low while a table read runs.
// (R10) Write-done at control bit 6 is low while a table write runs.
`timescale 1ns/1ps
`default_nettype none

module acl_entry_staging_regs (
  input  wire logic        ref_clk_in,
  input  wire logic        resetn_in,
  input  wire logic [13:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [13:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic [1:0]       priority_mode_field_out,
  output logic [2:0]       priority_out,
  output logic             remark_priority_enable_out,
  output logic [2:0]       remark_priority_out,
  output logic [1:0]       map_mode_field_out,
  output logic [6:0]       forward_port_map_out,
  output logic [15:0]      ruleset_out,
  output logic             xfer_busy_out
);

  function automatic logic reg_mapped(input logic [11:0] idx);
    return (idx >= acl_staging_pkg::IDX_MAC_ADDR_23_16) &&
           (idx <= acl_staging_pkg::IDX_ACCESS_CTRL);
  endfunction : reg_mapped

  function automatic logic is_staging(input logic [11:0] idx);
    return (idx >= acl_staging_pkg::IDX_MAC_ADDR_23_16) &&
           (idx <= acl_staging_pkg::IDX_RULESET_LOW);
  endfunction : is_staging

  logic                        rst_meta_r;
  logic                        rst_n_r;
  logic                        aw_held_r;
  logic                        w_held_r;
  logic [11:0]                 wr_idx_r;
  logic [7:0]                  wbyte_r;
  logic                        wlane0_r;
  logic                        bvalid_r;
  logic [1:0]                  bresp_r;
  logic                        rvalid_r;
  logic [1:0]                  rresp_r;
  logic [31:0]                 rdata_r;
  logic [7:0]                  rd_byte;
  logic [11:0]                 rd_idx;
  logic                        wr_fire;
  logic                        reg_wr;
  logic                        sel_lo_wr;
  logic                        start;
  logic [7:0]                  stage_r [acl_staging_pkg::ENTRY_BYTES];
  logic [7:0]                  sel_hi_r;
  logic [7:0]                  sel_lo_r;
  logic                        dir_r;
  logic [3:0]                  acl_index_r;
  logic [3:0]                  xfer_idx_r;
  logic                        wr_done_r;
  logic                        rd_done_r;
  acl_staging_pkg::xfer_state_t state_r;
  logic [127:0]                entry_wdata;
  logic [127:0]                entry_rdata;
  logic [15:0]                 lane_sel;

  // async assert, clocked release
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // write address and data accepted in either order
  assign s_axi_awready_out = !aw_held_r;
  assign s_axi_wready_out  = !w_held_r;
  assign wr_fire           = aw_held_r && w_held_r && !bvalid_r;
  assign reg_wr            = wr_fire && wlane0_r && reg_mapped(wr_idx_r);

  always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      aw_held_r <= 1'b0;
      wr_idx_r  <= '0;
    end else if (s_axi_awvalid_in && !aw_held_r) begin
      aw_held_r <= 1'b1;
      wr_idx_r  <= s_axi_awaddr_in[13:2];
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      w_held_r <= 1'b0;
      wbyte_r  <= '0;
      wlane0_r <= 1'b0;
    end else if (s_axi_wvalid_in && !w_held_r) begin
      w_held_r <= 1'b1;
      wbyte_r  <= s_axi_wdata_in[7:0];
      wlane0_r <= s_axi_wstrb_in[0];
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      bvalid_r <= 1'b0;
      bresp_r  <= acl_staging_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= reg_mapped(wr_idx_r) ? acl_staging_pkg::RESP_OKAY
                                       : acl_staging_pkg::RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out  = bresp_r;
  // read path, answer one cycle after the address
  assign rd_idx = s_axi_araddr_in[13:2];
  always_comb begin
    rd_byte = 8'h00;
    if (is_staging(rd_idx)) begin
      rd_byte = stage_r[rd_idx[3:0]];
    end else if (rd_idx == acl_staging_pkg::IDX_BYTE_SEL_HIGH) begin
      rd_byte = sel_hi_r;
    end else if (rd_idx == acl_staging_pkg::IDX_BYTE_SEL_LOW) begin
      rd_byte = sel_lo_r;
    end else if (rd_idx == acl_staging_pkg::IDX_ACCESS_CTRL) begin
      rd_byte = {1'b0, wr_done_r, rd_done_r, dir_r, acl_index_r};
    end
  end
  assign s_axi_arready_out = !rvalid_r;
  always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rvalid_r <= 1'b0;
      rresp_r  <= acl_staging_pkg::RESP_OKAY;
      rdata_r  <= '0;
    end else if (s_axi_arvalid_in && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rresp_r  <= reg_mapped(rd_idx) ? acl_staging_pkg::RESP_OKAY
                                     : acl_staging_pkg::RESP_SLVERR;
      rdata_r  <= {24'h000000, rd_byte};
    end else if (s_axi_rready_in) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rresp_out  = rresp_r;
  assign s_axi_rdata_out  = rdata_r;
  // (R1) low select write starts transfer
  assign sel_lo_wr = reg_wr && (wr_idx_r == acl_staging_pkg::IDX_BYTE_SEL_LOW);
  // a start while busy is dropped, the select value is still stored
  assign start     = sel_lo_wr && (state_r == acl_staging_pkg::XFER_IDLE);

  always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sel_hi_r <= acl_staging_pkg::SEL_RESET;
      sel_lo_r <= acl_staging_pkg::SEL_RESET;
    end else if (reg_wr && wr_idx_r == acl_staging_pkg::IDX_BYTE_SEL_HIGH) begin
      sel_hi_r <= wbyte_r;
    end else if (sel_lo_wr) begin
      sel_lo_r <= wbyte_r;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dir_r       <= 1'b0;
      acl_index_r <= '0;
    end else if (reg_wr && wr_idx_r == acl_staging_pkg::IDX_ACCESS_CTRL) begin
      dir_r       <= wbyte_r[acl_staging_pkg::CTRL_DIR];
      acl_index_r <= wbyte_r[3:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r    <= acl_staging_pkg::XFER_IDLE;
      xfer_idx_r <= '0;
    end else begin
      case (state_r)
        acl_staging_pkg::XFER_IDLE: begin
          if (start) begin
            xfer_idx_r <= acl_index_r;
            state_r    <= dir_r ? acl_staging_pkg::XFER_WRITE
                                : acl_staging_pkg::XFER_RD_ISSUE;
          end
        end
        acl_staging_pkg::XFER_WRITE:    state_r <= acl_staging_pkg::XFER_IDLE;
        acl_staging_pkg::XFER_RD_ISSUE: state_r <= acl_staging_pkg::XFER_RD_LOAD;
        acl_staging_pkg::XFER_RD_LOAD:  state_r <= acl_staging_pkg::XFER_IDLE;
        default:                        state_r <= acl_staging_pkg::XFER_IDLE;
      endcase
    end
  end
  assign xfer_busy_out = (state_r != acl_staging_pkg::XFER_IDLE);
  // (R10) write-done low during a table write
  always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wr_done_r <= acl_staging_pkg::DONE_RESET;
    end else if (start && dir_r) begin
      wr_done_r <= 1'b0;
    end else if (state_r == acl_staging_pkg::XFER_WRITE) begin
      wr_done_r <= 1'b1;
    end
  end

  // (R9) read-done low until staging is loaded
  always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rd_done_r <= acl_staging_pkg::DONE_RESET;
    end else if (start && !dir_r) begin
      rd_done_r <= 1'b0;
    end else if (state_r == acl_staging_pkg::XFER_RD_LOAD) begin
      rd_done_r <= 1'b1;
    end
  end

  // (R2) (R3) lane i of the entry is byte 15-i, so selects concatenate
  assign lane_sel = {sel_hi_r, sel_lo_r};
  // (R8) byte 0 lands in the top lane, msb first
  always_comb begin
    entry_wdata = '0;
    for (int b = 0; b < acl_staging_pkg::ENTRY_BYTES; b++) begin
      entry_wdata[8*(15-b) +: 8] = stage_r[b];
    end
  end

  // (R4) unselected bytes keep their value on a read
  always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int b = 0; b < acl_staging_pkg::ENTRY_BYTES; b++) begin
        stage_r[b] <= acl_staging_pkg::STAGE_RESET;
      end
    end else begin
      if (state_r == acl_staging_pkg::XFER_RD_LOAD) begin
        for (int b = 0; b < acl_staging_pkg::ENTRY_BYTES; b++) begin
          if (lane_sel[15-b]) begin
            stage_r[b] <= entry_rdata[8*(15-b) +: 8];
          end
        end
      end
      // software write to the same byte overrides a load
      if (reg_wr && is_staging(wr_idx_r)) begin
        stage_r[wr_idx_r[3:0]] <= wbyte_r;
      end
    end
  end

  acl_entry_mem acl_entry_mem_inst (
    .clk_in     (ref_clk_in),
    .wr_en_in   (state_r == acl_staging_pkg::XFER_WRITE),
    .rd_en_in   (state_r == acl_staging_pkg::XFER_RD_ISSUE),
    .addr_in    (xfer_idx_r),
    .lane_en_in (lane_sel),
    .wdata_in   (entry_wdata),
    .rdata_out  (entry_rdata)
  );

  // (R7) priority byte fields
  assign priority_mode_field_out =
    stage_r[acl_staging_pkg::BYTE_PRIO][acl_staging_pkg::PM_HI:acl_staging_pkg::PM_LO];
  assign priority_out =
    stage_r[acl_staging_pkg::BYTE_PRIO][acl_staging_pkg::PRIO_HI:acl_staging_pkg::PRIO_LO];
  assign remark_priority_enable_out =
    stage_r[acl_staging_pkg::BYTE_PRIO][acl_staging_pkg::RPE_BIT];
  // (R5) remark priority split over two bytes
  assign remark_priority_out = {
    stage_r[acl_staging_pkg::BYTE_PRIO][acl_staging_pkg::RMK_UP_HI:acl_staging_pkg::RMK_UP_LO],
    stage_r[acl_staging_pkg::BYTE_MAP_MODE][acl_staging_pkg::RMK_LSB]};
  assign map_mode_field_out =
    stage_r[acl_staging_pkg::BYTE_MAP_MODE][acl_staging_pkg::MM_HI:acl_staging_pkg::MM_LO];
  // (R6) bit i is port i+1
  assign forward_port_map_out =
    stage_r[acl_staging_pkg::BYTE_FWD_MAP][acl_staging_pkg::FWD_HI:acl_staging_pkg::FWD_LO];
  // (R8) ruleset high byte first
  assign ruleset_out = {stage_r[acl_staging_pkg::BYTE_RULES_HI],
                        stage_r[acl_staging_pkg::BYTE_RULES_LO]};

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_r);

  sequence s_read_runs;
    !rd_done_r ##1 !rd_done_r ##1 rd_done_r;
  endsequence
  sequence s_write_runs;
    !wr_done_r ##1 wr_done_r;
  endsequence
  a_start_on_low: assert property ( // (R1)
    reg_wr && wr_idx_r == acl_staging_pkg::IDX_BYTE_SEL_HIGH &&
    state_r == acl_staging_pkg::XFER_IDLE |=> !xfer_busy_out)
    else $error("high select write started a transfer");
  a_low_starts_xfer: assert property ( // (R1)
    start |=> xfer_busy_out)
    else $error("low select write did not start a transfer");
  a_hi_select_map: assert property ( // (R2)
    state_r == acl_staging_pkg::XFER_RD_LOAD && sel_hi_r[0]
    |=> stage_r[7] == $past(entry_rdata[71:64]) || $past(reg_wr))
    else $error("high select bit 0 did not load byte 7");
  a_lo_select_map: assert property ( // (R3)
    state_r == acl_staging_pkg::XFER_RD_LOAD && sel_lo_r[0]
    |=> stage_r[15] == $past(entry_rdata[7:0]) || $past(reg_wr))
    else $error("low select bit 0 did not load byte 15");
  a_unselected_kept: assert property ( // (R4)
    state_r == acl_staging_pkg::XFER_RD_LOAD && !sel_lo_r[7] && !reg_wr
    |=> $stable(stage_r[8]))
    else $error("unselected byte changed on a read");
  a_remark_lsb: assert property ( // (R5)
    reg_wr && wr_idx_r == acl_staging_pkg::IDX_REMARK_MAP_MODE
    |=> remark_priority_out[0] == $past(wbyte_r[7]))
    else $error("remark priority lsb not taken from bit 7");
  a_forward_map: assert property ( // (R6)
    reg_wr && wr_idx_r == acl_staging_pkg::IDX_FORWARD_MAP
    |=> forward_port_map_out == $past(wbyte_r[6:0]))
    else $error("forward map not taken from bits 6:0");
  a_prio_fields: assert property ( // (R7)
    reg_wr && wr_idx_r == acl_staging_pkg::IDX_PRIO_REMARK
    |=> priority_mode_field_out == $past(wbyte_r[7:6]) &&
        priority_out == $past(wbyte_r[5:3]) &&
        remark_priority_enable_out == $past(wbyte_r[2]))
    else $error("priority fields misplaced");
  a_read_done_flag: assert property ( // (R9)
    start && !dir_r |=> s_read_runs)
    else $error("read-done flag sequence wrong");
  a_write_done_flag: assert property ( // (R10)
    start && dir_r |=> s_write_runs)
    else $error("write-done flag sequence wrong");

endmodule : acl_entry_staging_regs

`default_nettype wire

// >>> sim/acl_entry_staging_regs_tb.sv
/*
  Self-checking bench for the ACL entry staging bank: AXI4-Lite register
  tasks, a small table model for indirect transfers, field output checks.
  Assumes the package constants and the 125 MHz single-clock design.
*/
`timescale 1ns/1ps
`default_nettype none

module acl_entry_staging_regs_tb;
  logic        clk;
  logic        resetn;
  logic [13:0] awaddr;
  logic [13:0] araddr;
  logic        awvalid;
  logic        wvalid;
  logic        bready;
  logic        arvalid;
  logic        rready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [3:0]  strb;
  logic        awready;
  logic        wready;
  logic        bvalid;
  logic        arready;
  logic        rvalid;
  logic        busy;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [31:0] rdata;
  logic [1:0]  pm;
  logic [2:0]  prio;
  logic        remark_priority_enable;
  logic [2:0]  remark;
  logic [1:0]  mm;
  logic [6:0]  fwd;
  logic [15:0] rules;
  int          miscompares;
  int          compares;
  int          cycles;
  logic        busy_seen;
  logic [7:0]  stage [16];
  logic [7:0]  tbl [16][16];

  acl_entry_staging_regs acl_entry_staging_regs_inst (
    .ref_clk_in                 (clk),
    .resetn_in                  (resetn),
    .s_axi_awaddr_in            (awaddr),
    .s_axi_awvalid_in           (awvalid),
    .s_axi_awready_out          (awready),
    .s_axi_wdata_in             (wdata),
    .s_axi_wstrb_in             (wstrb),
    .s_axi_wvalid_in            (wvalid),
    .s_axi_wready_out           (wready),
    .s_axi_bresp_out            (bresp),
    .s_axi_bvalid_out           (bvalid),
    .s_axi_bready_in            (bready),
    .s_axi_araddr_in            (araddr),
    .s_axi_arvalid_in           (arvalid),
    .s_axi_arready_out          (arready),
    .s_axi_rdata_out            (rdata),
    .s_axi_rresp_out            (rresp),
    .s_axi_rvalid_out           (rvalid),
    .s_axi_rready_in            (rready),
    .priority_mode_field_out    (pm),
    .priority_out               (prio),
    .remark_priority_enable_out (remark_priority_enable),
    .remark_priority_out        (remark),
    .map_mode_field_out         (mm),
    .forward_port_map_out       (fwd),
    .ruleset_out                (rules),
    .xfer_busy_out              (busy)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // pre-edge view of busy, free of edge races
  always @(negedge clk) begin
    if (busy === 1'b1) busy_seen = 1'b1;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // handshakes judged on pre-edge values taken at the falling edge
  task automatic axi_wr(input logic [11:0] idx, input logic [7:0] val, output logic [1:0] resp);
    int   n;
    logic aw_hit;
    logic w_hit;
    logic b_hit;
    @(posedge clk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h000000, val};
    wstrb   <= strb;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    b_hit = 1'b0;
    while (!b_hit && n < 200) begin
      @(negedge clk);
      aw_hit = awvalid & awready;
      w_hit = wvalid & wready;
      b_hit = bvalid & bready;
      resp = bresp;
      @(posedge clk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      if (b_hit) bready <= 1'b0;
      n++;
    end
    if (!b_hit) miscompares++;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] resp);
    int   n;
    logic ar_hit;
    logic r_hit;
    @(posedge clk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    r_hit = 1'b0;
    while (!r_hit && n < 200) begin
      @(negedge clk);
      ar_hit = arvalid & arready;
      r_hit = rvalid & rready;
      d = rdata;
      resp = rresp;
      @(posedge clk);
      if (ar_hit) arvalid <= 1'b0;
      if (r_hit) rready <= 1'b0;
      n++;
    end
    if (!r_hit) miscompares++;
  endtask : axi_rd

  task automatic wr_reg(input logic [11:0] idx, input logic [7:0] val);
    logic [1:0] r;
    axi_wr(idx, val, r);
    check("bresp", r, acl_staging_pkg::RESP_OKAY);
    if (idx >= 12'h605 && idx <= 12'h60f) stage[idx[3:0]] = val;
  endtask : wr_reg

  task automatic chk_reg(input logic [11:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(idx, d, r);
    check("rresp", r, acl_staging_pkg::RESP_OKAY);
    check("rdata", d, {24'h000000, exp});
  endtask : chk_reg

  task automatic chk_stage();
    for (int i = 5; i < 16; i++) chk_reg(12'h600 + 12'(i), stage[i]);
  endtask : chk_stage

  task automatic chk_fields();
    check("prio_mode", pm, stage[10][7:6]);
    check("prio", prio, stage[10][5:3]);
    check("remark_en", remark_priority_enable, stage[10][2]);
    check("remark", remark, {stage[10][1:0], stage[11][7]});
    check("map_mode", mm, stage[11][6:5]);
    check("fwd_map", fwd, stage[13][6:0]);
    check("ruleset", rules, {stage[14], stage[15]});
  endtask : chk_fields

  task automatic xfer(input logic dir, input logic [3:0] idx, input logic [7:0] hi,
                      input logic [7:0] lo);
    int          n;
    logic [31:0] d;
    logic [1:0]  r;
    logic        sel;
    wr_reg(acl_staging_pkg::IDX_ACCESS_CTRL, {3'b000, dir, idx});
    wr_reg(acl_staging_pkg::IDX_BYTE_SEL_HIGH, hi);
    busy_seen = 1'b0;
    // low select written last starts it
    wr_reg(acl_staging_pkg::IDX_BYTE_SEL_LOW, lo);
    for (int b = 0; b < 16; b++) begin
      sel = (b < 8) ? hi[7 - b] : lo[15 - b];
      if (sel && dir) tbl[idx][b] = stage[b];
      if (sel && !dir) stage[b] = tbl[idx][b];
    end
    n = 0;
    d = '0;
    while (d[dir ? 6 : 5] !== 1'b1 && n < 20) begin
      axi_rd(acl_staging_pkg::IDX_ACCESS_CTRL, d, r);
      n++;
    end
    check("busy_seen", busy_seen, 1'b1);
    chk_reg(acl_staging_pkg::IDX_ACCESS_CTRL, {3'b011, dir, idx});
  endtask : xfer

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    resetn = 1'b0;
    awaddr = '0;
    araddr = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = '0;
    wstrb = '0;
    strb = 4'h1;
    miscompares = 0;
    compares = 0;
    cycles = 0;
    busy_seen = 1'b0;
    for (int i = 0; i < 16; i++) stage[i] = 8'h00;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 5; i < 18; i++) chk_reg(12'h600 + 12'(i), 8'h00);
    chk_reg(acl_staging_pkg::IDX_ACCESS_CTRL, 8'h60);
    chk_fields();
    // internal-only and out-of-range places answer with an error
    axi_rd(12'h600, d, r);
    check("unmapped_rresp", r, acl_staging_pkg::RESP_SLVERR);
    check("unmapped_rdata", d, 32'h00000000);
    axi_wr(12'h613, 8'hff, r);
    check("unmapped_bresp", r, acl_staging_pkg::RESP_SLVERR);
    for (int i = 5; i < 16; i++) wr_reg(12'h600 + 12'(i), {4'(i), ~4'(i)});
    xfer(1'b1, 4'h3, 8'hff, 8'hff);
    chk_stage();
    chk_reg(acl_staging_pkg::IDX_BYTE_SEL_HIGH, 8'hff);
    chk_reg(acl_staging_pkg::IDX_BYTE_SEL_LOW, 8'hff);
    wr_reg(acl_staging_pkg::IDX_PRIO_REMARK, 8'hb6);
    wr_reg(acl_staging_pkg::IDX_REMARK_MAP_MODE, 8'hc5);
    wr_reg(acl_staging_pkg::IDX_FORWARD_MAP, 8'ha5);
    wr_reg(acl_staging_pkg::IDX_RULESET_HIGH, 8'h12);
    wr_reg(acl_staging_pkg::IDX_RULESET_LOW, 8'h34);
    chk_fields();
    // lane 0 strobe off: acknowledged, register untouched
    strb = 4'h0;
    axi_wr(acl_staging_pkg::IDX_RULESET_LOW, 8'hee, r);
    strb = 4'h1;
    check("nolane_bresp", r, acl_staging_pkg::RESP_OKAY);
    chk_fields();
    // full entry out, wipe staging, then a sparse read brings back four bytes
    xfer(1'b1, 4'h5, 8'hff, 8'hff);
    for (int i = 5; i < 16; i++) wr_reg(12'h600 + 12'(i), 8'h00);
    xfer(1'b0, 4'h5, 8'h05, 8'h21);
    chk_stage();
    chk_fields();
    xfer(1'b0, 4'h3, 8'h00, 8'hc0);
    chk_stage();
    chk_fields();
    results();
  end
endmodule : acl_entry_staging_regs_tb

`default_nettype wire
